// *** rtl/sgb_pkg.sv ***
// Constants for the segment pattern, blink, cursor and scroll logic
package sgb_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_SEG_BASE = 4'h0; // Index 0..f segment pattern words
  localparam logic [4:0] ADDR_CTRL = 5'h10;
  localparam logic [4:0] ADDR_ADDR_CNT = 5'h11;
  localparam logic [4:0] ADDR_SCROLL = 5'h12;
  localparam logic [4:0] ADDR_PORT = 5'h13;
  localparam logic [4:0] ADDR_SEG_DATA = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h15;
  // Control fields
  localparam int CTRL_FONT6 = 0;
  localparam int CTRL_BLINK_EN = 1;
  localparam int CTRL_TWO_LINE = 2;
  localparam int CTRL_INC = 3;
  localparam int CTRL_EXT_CLK = 4;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  // Segment word fields
  localparam int SEG_SET_BLINK = 7;
  localparam int SEG_ONE_BLINK = 6;
  localparam int SEG_BIT5 = 5;
  localparam int SEG_BIT4 = 4;
  // Segment counts
  localparam int SEG_WORDS = 16;
  localparam logic [6:0] SEG_LAST_5 = 7'h4f; // Segment 80
  localparam logic [6:0] SEG_LAST_6 = 7'h5f; // Segment 96
  localparam logic [6:0] SEG_LOCAL_1L = 7'h32; // 50
  localparam logic [6:0] SEG_LOCAL_2L = 7'h2a; // 42
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int BLINK_DIV_BITS = 15; // Half blink period is 2^14 oscillator edges
  localparam int SCAN_COMMONS = 17;
  localparam logic [4:0] SEG_COMMON_IDX = 5'h10;
  localparam logic [4:0] SCAN_LAST = 5'h10;
  localparam logic [7:0] ROW_DIV = 8'hff;
endpackage : sgb_pkg

// *** rtl/sgb_core.sv ***
// Segment pattern memory, blink, cursor position, scroll and port logic
`timescale 1ns/100ps
// ----------------------------------------
// Summary of operation
// R1: Five-dot width uses word bits 4..0 for five segments.
// R2: Six-dot width uses word bits 5..0 for six segments.
// R3: Bit 5 ignored in five-dot width.
// R4: Address 0 feeds first segments; higher bit drives lower segment.
// R5: Segment sequence wraps after segment 80 or 96.
// R6: Pattern drives segments only while segment common line is scanned.
// R7: One lights a segment, zero leaves it dark.
// R8: Bit 7 with blink enable blinks all set pattern bits.
// R9: Bit 6 with blink enable blinks only bit 4 or bit 5.
// R10: Segments 1..50 or 1..42 local, rest shifted to extension.
// R11: Cursor attribute sits at address counter position.
// R12: Cursor attribute stays active whatever memory the counter addresses.
// R13: Horizontal scroll moves in single dot steps.
// R14: Per-line scroll selection honoured only in two-line mode.
// R15: Two general outputs set from register bits.
// R16: Blink and scan row timing derived from one oscillator clock; segments step on clk.
// R17: External clock may replace the internal oscillator.
// R18: Segment access steps counter up or down by entry direction.
// R19: Segment or glyph access never shifts the display.
// R20: One shared blink phase from a fixed divider.
// ----------------------------------------
module sgb_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic osc_int,
  input wire logic osc_ext,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic seg_valid,
  output logic [6:0] seg_index,
  output logic seg_on,
  output logic seg_local,
  output logic ext_shift,
  output logic [4:0] common_sel,
  output logic [6:0] cursor_pos,
  output logic blink_phase,
  output logic [5:0] scroll_line1,
  output logic [5:0] scroll_line2,
  output logic [1:0] gp_port,
  output logic timebase_tick
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] segment_pattern_ram [sgb_pkg::SEG_WORDS];
  logic [7:0] ctrl;
  logic [6:0] address_counter;
  logic [7:0] scroll;
  logic osc_q;
  logic osc_edge;
  logic [sgb_pkg::BLINK_DIV_BITS-1:0] blink_div;
  logic [7:0] row_div;
  logic [4:0] scan_row;
  logic [6:0] seg_cnt;
  logic [2:0] bit_cnt;
  logic seg_acc;
  logic font6;
  logic blink_enable_bit;
  logic [7:0] cur_word;
  logic [2:0] bit_pos;
  logic pat;
  logic blinked;
  logic [6:0] last_seg;
  logic [6:0] local_lim;
  logic [6:0] word_idx;

  assign font6 = ctrl[sgb_pkg::CTRL_FONT6];
  assign blink_enable_bit = ctrl[sgb_pkg::CTRL_BLINK_EN];
  assign seg_acc = (addr == sgb_pkg::ADDR_SEG_DATA) && (wr || rd);

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  // R17: external clock select
  // R16: single timebase source
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      osc_q <= 1'b0;
    else
      osc_q <= ctrl[sgb_pkg::CTRL_EXT_CLK] ? osc_ext : osc_int;
  end
  // Edge of the chosen oscillator, time step of the blink and row dividers below
  assign osc_edge = (ctrl[sgb_pkg::CTRL_EXT_CLK] ? osc_ext : osc_int) && !osc_q;

  // R20: shared blink divider
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      blink_div <= '0;
    else if (osc_edge)
      blink_div <= blink_div + sgb_pkg::BLINK_DIV_BITS'(1);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      row_div <= 8'h00;
      scan_row <= 5'h00;
    end
    else if (osc_edge)
    begin
      row_div <= row_div + 8'h01;
      if (row_div == sgb_pkg::ROW_DIV)
        scan_row <= (scan_row == sgb_pkg::SCAN_LAST) ? 5'h00 : scan_row + 5'h01;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl <= sgb_pkg::CTRL_RESET;
    else if (wr && addr == sgb_pkg::ADDR_CTRL)
      ctrl <= wdata;
  end

  // R13: dot-step offsets
  // R14: line select only in two-line mode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      scroll <= 8'h00;
    else if (wr && addr == sgb_pkg::ADDR_SCROLL)
      scroll <= wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scroll_line1 <= 6'h00;
      scroll_line2 <= 6'h00;
    end
    else
    begin
      scroll_line1 <= (!ctrl[sgb_pkg::CTRL_TWO_LINE] || scroll[6]) ? scroll[5:0] : 6'h00;
      scroll_line2 <= (ctrl[sgb_pkg::CTRL_TWO_LINE] && scroll[7]) ? scroll[5:0] : 6'h00;
    end
  end

  // R15: general outputs from register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      gp_port <= 2'b00;
    else if (wr && addr == sgb_pkg::ADDR_PORT)
      gp_port <= wdata[1:0];
  end

  // R18: step counter on segment access
  // R19: no display shift here
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      address_counter <= 7'h00;
    else if (wr && addr == sgb_pkg::ADDR_ADDR_CNT)
      address_counter <= wdata[6:0];
    else if (seg_acc)
      address_counter <= ctrl[sgb_pkg::CTRL_INC] ? address_counter + 7'h01 : address_counter - 7'h01;
  end

  generate
    for (genvar i = 0; i < sgb_pkg::SEG_WORDS; i++)
    begin : g_word
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          segment_pattern_ram[i] <= 8'h00;
        else if (wr && addr == {1'b0, 4'(i)})
          segment_pattern_ram[i] <= wdata;
        else if (wr && addr == sgb_pkg::ADDR_SEG_DATA && address_counter[3:0] == 4'(i))
          segment_pattern_ram[i] <= wdata;
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (!addr[4])
        rdata <= segment_pattern_ram[addr[3:0]];
      else if (addr == sgb_pkg::ADDR_CTRL)
        rdata <= ctrl;
      else if (addr == sgb_pkg::ADDR_ADDR_CNT)
        rdata <= {1'b0, address_counter};
      else if (addr == sgb_pkg::ADDR_SCROLL)
        rdata <= scroll;
      else if (addr == sgb_pkg::ADDR_PORT)
        rdata <= {6'h00, gp_port};
      else if (addr == sgb_pkg::ADDR_SEG_DATA)
        rdata <= segment_pattern_ram[address_counter[3:0]];
      else if (addr == sgb_pkg::ADDR_STATUS)
        rdata <= {2'b00, blink_phase, scan_row};
      else
        rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Segment serialiser
  // ----------------------------------------
  assign word_idx = seg_cnt / (font6 ? 7'd6 : 7'd5);
  assign cur_word = segment_pattern_ram[word_idx[3:0]];
  // R4: higher bit first
  // R1: five low bits
  // R2: six low bits
  assign bit_pos = font6 ? 3'd5 - bit_cnt : 3'd4 - bit_cnt;
  // R3: bit 5 unused at five dots
  // R7: one means lit
  assign pat = cur_word[bit_pos];
  // R8: blink set bits
  // R9: blink single bit
  assign blinked = blink_enable_bit && (cur_word[sgb_pkg::SEG_SET_BLINK] ||
    (cur_word[sgb_pkg::SEG_ONE_BLINK] && bit_pos == (font6 ? 3'd5 : 3'd4)));
  assign last_seg = font6 ? sgb_pkg::SEG_LAST_6 : sgb_pkg::SEG_LAST_5;
  assign local_lim = ctrl[sgb_pkg::CTRL_TWO_LINE] ? sgb_pkg::SEG_LOCAL_2L : sgb_pkg::SEG_LOCAL_1L;

  // R5: wrap after last segment
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seg_cnt <= 7'h00;
      bit_cnt <= 3'd0;
    end
    // At or past the end, so a font change mid-row cannot run the count away
    else if (seg_cnt >= last_seg || scan_row != sgb_pkg::SEG_COMMON_IDX)
    begin
      seg_cnt <= 7'h00;
      bit_cnt <= 3'd0;
    end
    else
    begin
      seg_cnt <= seg_cnt + 7'h01;
      bit_cnt <= (bit_cnt == (font6 ? 3'd5 : 3'd4)) ? 3'd0 : bit_cnt + 3'd1;
    end
  end

  // R6: output only on segment common line
  // R10: local or extension
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seg_valid <= 1'b0;
      seg_index <= 7'h00;
      seg_on <= 1'b0;
      seg_local <= 1'b0;
      ext_shift <= 1'b0;
    end
    else
    begin
      seg_valid <= (scan_row == sgb_pkg::SEG_COMMON_IDX);
      seg_index <= seg_cnt;
      seg_on <= (scan_row == sgb_pkg::SEG_COMMON_IDX) && pat && !(blinked && blink_phase);
      seg_local <= (scan_row == sgb_pkg::SEG_COMMON_IDX) && (seg_cnt < local_lim);
      ext_shift <= (scan_row == sgb_pkg::SEG_COMMON_IDX) && (seg_cnt >= local_lim);
    end
  end

  // ----------------------------------------
  // Cursor and shared outputs
  // ----------------------------------------
  // R11: cursor at counter
  // R12: regardless of target memory
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cursor_pos <= 7'h00;
      blink_phase <= 1'b0;
      common_sel <= 5'h00;
      timebase_tick <= 1'b0;
    end
    else
    begin
      cursor_pos <= address_counter;
      blink_phase <= blink_div[sgb_pkg::BLINK_DIV_BITS-1];
      common_sel <= scan_row;
      timebase_tick <= osc_edge;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // R18: counter step
  chk_addr_step: assert property (@(posedge clk) disable iff (!resetn) // R18
    seg_acc && !(wr && addr == sgb_pkg::ADDR_ADDR_CNT) && ctrl[sgb_pkg::CTRL_INC]
    |=> address_counter == $past(address_counter) + 7'h01)
    else $error("address counter did not step up");
  // R6: gated by common line
  chk_seg_gate: assert property (@(posedge clk) disable iff (!resetn) // R6
    seg_on |-> seg_valid)
    else $error("segment lit outside common line");
  // R15: port follows write
  chk_port_write: assert property (@(posedge clk) disable iff (!resetn) // R15
    wr && addr == sgb_pkg::ADDR_PORT |=> gp_port == $past(wdata[1:0]))
    else $error("port not updated");
  // R11: cursor follows counter
  chk_cursor_pos: assert property (@(posedge clk) disable iff (!resetn) // R11
    ##1 cursor_pos == $past(address_counter))
    else $error("cursor off counter");
  // R14: line 2 idle in one-line mode
  chk_scroll_mode: assert property (@(posedge clk) disable iff (!resetn) // R14
    !ctrl[sgb_pkg::CTRL_TWO_LINE] |=> scroll_line2 == 6'h00)
    else $error("line two scrolled in one-line mode");
  // R5: wrap bound
  chk_seg_wrap: assert property (@(posedge clk) disable iff (!resetn) // R5
    seg_cnt <= sgb_pkg::SEG_LAST_6)
    else $error("segment index past end");
  // R10: local and extension exclusive
  chk_ext_split: assert property (@(posedge clk) disable iff (!resetn) // R10
    !(seg_local && ext_shift))
    else $error("segment both local and extension");
  // R8: blink hides set bit
  chk_blink_off: assert property (@(posedge clk) disable iff (!resetn) // R8
    blinked && blink_phase |=> !seg_on)
    else $error("blinked segment lit in off phase");
  cov_seg_lit: cover property (@(posedge clk) disable iff (!resetn) seg_on);
  cov_ext: cover property (@(posedge clk) disable iff (!resetn) ext_shift);
  cov_seg_acc: cover property (@(posedge clk) disable iff (!resetn) seg_acc);
  cov_blink_off: cover property (@(posedge clk) disable iff (!resetn) seg_valid && blinked && blink_phase);

endmodule : sgb_core

// *** tb/sgb_host_model.sv ***
// Host controller model driving the register port
`timescale 1ns/100ps
module sgb_host_model (
  input wire logic clk,
  output logic [4:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial
  begin
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // ports set like any register
  task automatic write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Released data shows no stale value
    wdata <= ~d;
  endtask : write
  task automatic read(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : read
endmodule : sgb_host_model

// *** tb/test_sgb_core.sv ***
// Testbench for the segment pattern, cursor and port logic
`timescale 1ns/100ps
module test_sgb_core;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic osc_int = 1'b0;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic seg_valid;
  logic [6:0] seg_index;
  logic seg_on;
  logic seg_local;
  logic [6:0] cursor_pos;
  logic [1:0] gp_port;
  logic ext_shift;
  logic [4:0] common_sel;
  logic blink_phase;
  logic [5:0] scroll_line1;
  logic [5:0] scroll_line2;
  logic timebase_tick;
  logic osc_ext = 1'b0;
  logic osc_seen;
  logic [sgb_pkg::BLINK_DIV_BITS-1:0] osc_edges;
  logic exp_phase;
  logic seg_phase;
  logic [7:0] mem [16];
  int errors = 0;
  int samples_checked = 0;
  sgb_core u_sgb_core (.clk(clk), .resetn(resetn), .osc_int(osc_int), .osc_ext(osc_ext), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .seg_valid(seg_valid), .seg_index(seg_index),
    .seg_on(seg_on), .seg_local(seg_local), .ext_shift(ext_shift), .common_sel(common_sel),
    .cursor_pos(cursor_pos), .blink_phase(blink_phase), .scroll_line1(scroll_line1),
    .scroll_line2(scroll_line2), .gp_port(gp_port), .timebase_tick(timebase_tick));
  sgb_host_model u_sgb_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  always #4 clk = ~clk;
  // Fast oscillator keeps a full frame short
  always @(posedge clk) osc_int <= ~osc_int;
  // Own count of oscillator edges gives the expected blink phase
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_seen <= 1'b0;
      osc_edges <= '0;
      exp_phase <= 1'b0;
      seg_phase <= 1'b0;
    end
    else
    begin
      osc_seen <= osc_int;
      if (osc_int && !osc_seen)
        osc_edges <= osc_edges + 1'b1;
      exp_phase <= osc_edges[sgb_pkg::BLINK_DIV_BITS-1];
      seg_phase <= exp_phase;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_sgb_host_model.read(a, d);
    check(name, exp, d);
  endtask : rd_chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    rd_chk("ctrl", 5'h10, 8'h08);
    rd_chk("unmapped", 5'h1f, 8'h00);
    u_sgb_host_model.write(5'h1f, 8'hff);
    rd_chk("ctrl", 5'h10, 8'h08);
    u_sgb_host_model.write(5'h13, 8'h02);
    @(negedge clk);
    check("gp_port", 8'h02, 8'(gp_port));
    u_sgb_host_model.write(5'h13, 8'h01);
    @(negedge clk);
    check("gp_port", 8'h01, 8'(gp_port));
    $display("test regs done");
  endtask : test_regs
  task automatic test_counter();
    u_sgb_host_model.write(5'h11, 8'h08);
    repeat (2) @(negedge clk);
    check("cursor_pos", 8'h08, 8'(cursor_pos));
    u_sgb_host_model.write(5'h11, 8'h00);
    u_sgb_host_model.write(5'h14, 8'h3a);
    u_sgb_host_model.write(5'h14, 8'h25);
    rd_chk("counter", 5'h11, 8'h02);
    rd_chk("word0", 5'h00, 8'h3a);
    rd_chk("word1", 5'h01, 8'h25);
    u_sgb_host_model.write(5'h10, 8'h00);
    u_sgb_host_model.write(5'h14, 8'h11);
    rd_chk("counter", 5'h11, 8'h01);
    rd_chk("word2", 5'h02, 8'h11);
    check("cursor_pos", 8'h01, 8'(cursor_pos));
    $display("test counter done");
  endtask : test_counter
  // Line offsets follow the select bits only with two lines shown
  task automatic test_scroll();
    u_sgb_host_model.write(5'h12, 8'h85);
    repeat (2) @(negedge clk);
    check("scroll_line1", 8'h05, 8'(scroll_line1));
    check("scroll_line2", 8'h00, 8'(scroll_line2));
    u_sgb_host_model.write(5'h10, 8'h0c);
    repeat (2) @(negedge clk);
    check("scroll_line1", 8'h00, 8'(scroll_line1));
    check("scroll_line2", 8'h05, 8'(scroll_line2));
    u_sgb_host_model.write(5'h12, 8'h6b);
    repeat (2) @(negedge clk);
    check("scroll_line1", 8'h2b, 8'(scroll_line1));
    check("scroll_line2", 8'h00, 8'(scroll_line2));
    rd_chk("scroll", 5'h12, 8'h6b);
    u_sgb_host_model.write(5'h10, 8'h08);
    $display("test scroll done");
  endtask : test_scroll
  // Pattern bits walk out in segment order, wrapping at the last
  task automatic test_scan(input logic font6, input logic two_line, input logic blink);
    int n;
    int top;
    int w;
    int b;
    int s;
    int segs;
    logic blk;
    segs = font6 ? 96 : 80;
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 8'(((i * 11 + 7) & 63) | ((i & 3) << 6));
      u_sgb_host_model.write(5'(i), mem[i]);
    end
    u_sgb_host_model.write(5'h10, {5'h01, two_line, blink, font6});
    n = 0;
    top = 0;
    s = 0;
    while (seg_valid !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    check("seg_valid", 8'h01, 8'(seg_valid));
    while (seg_valid === 1'b1)
    begin
      w = (s % segs) / (font6 ? 6 : 5);
      b = font6 ? 5 - (s % segs) % 6 : 4 - (s % segs) % 5;
      blk = blink && seg_phase && (mem[w][7] || (mem[w][6] && b == (font6 ? 5 : 4)));
      check("seg_index", 8'(s % segs), 8'(seg_index));
      check("seg_on", 8'(mem[w][b] && !blk), 8'(seg_on));
      check("seg_local", 8'((s % segs) < (two_line ? 42 : 50)), 8'(seg_local));
      check("ext_shift", 8'((s % segs) >= (two_line ? 42 : 50)), 8'(ext_shift));
      check("common_sel", 8'h10, 8'(common_sel));
      check("blink_phase", 8'(exp_phase), 8'(blink_phase));
      if (seg_index > top)
        top = seg_index;
      s++;
      @(negedge clk);
    end
    check("common_sel", 8'h00, 8'(common_sel));
    check("last_segment", font6 ? 8'd95 : 8'd79, 8'(top));
    $display("test scan done");
  endtask : test_scan
  // External source replaces the internal oscillator; run last, it breaks the phase count
  task automatic test_ext_clock();
    int ticks;
    ticks = 0;
    u_sgb_host_model.write(5'h10, 8'h18);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      osc_ext <= (i == 3 || i == 7);
      @(negedge clk);
      if (timebase_tick === 1'b1)
        ticks++;
    end
    check("ext_ticks", 8'h02, 8'(ticks));
    u_sgb_host_model.write(5'h10, 8'h08);
    $display("test ext clock done");
  endtask : test_ext_clock
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    test_regs();
    test_counter();
    test_scroll();
    test_scan(1'b0, 1'b0, 1'b0);
    test_scan(1'b1, 1'b1, 1'b1);
    test_scan(1'b1, 1'b0, 1'b0);
    test_scan(1'b0, 1'b1, 1'b1);
    test_scan(1'b1, 1'b0, 1'b1);
    test_ext_clock();
    final_report();
  end
  // Five scan windows, the last two in the blink off phase, fit well inside
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule : test_sgb_core
